// >>> testbench.sv
// Self-checking testbench for the watchdog timer core
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin fails++; $display("FAIL %0t %s", $time, msg); end end
module testbench;
    import wdt_pkg::*;
    // Clock, reset and stimulus
    logic        clk_sys;
    logic        srst;
    wdt_opt_s    opt;
    wdt_wr_s     wr;
    logic        psel, csel, rsel, stp, wai, ew1, susp;
    logic        osc = 1'h0;                  // Driven only by the oscillator stand-in
    // Observed outputs
    logic [14:0] count;
    logic        running, flag, prot, osc_en, irq, rreq;
    // Scoreboard and model state
    int          fails, checks, n;
    int unsigned seed;
    logic [14:0] c;
    // Protected reload per selection code; unprotected is always full scale
    logic [14:0] tab [4] = '{15'h03FF, 15'h0FFF, 15'h1FFF, 15'h3FFF};

    wdt_core u_dut (.clk_sys(clk_sys), .srst(srst), .opt(opt), .wr(wr), .prescaler_select_bit(psel),
        .system_clock_select_bit(csel), .underflow_reset_sel(rsel), .dedicated_osc_clock(osc),
        .stop_mode(stp), .wait_mode(wai), .erase_write_mode_one(ew1), .flash_suspend(susp),
        .count(count), .running(running), .watchdog_detect_flag(flag), .protection_mode_bit(prot),
        .osc_enable(osc_en), .wdt_irq(irq), .wdt_reset_req(rreq));

    // Free-running 40 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Oscillator stand-in: one pulse every second system cycle
    always @(posedge clk_sys) begin
        osc <= ~osc;
    end

    // Fixed-seed xorshift source
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Model reload value for a protection state and selection code
    function automatic logic [14:0] rl(logic p, logic [1:0] s);
        return p ? tab[s] : 15'h7FFF;
    endfunction

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Reset with given options; reset values checked before release
    task automatic do_reset(logic st, logic pr, logic [1:0] iv, logic [1:0] wn);
        @(posedge clk_sys);
        srst <= 1'h1;
        opt  <= '{st, pr, iv, wn};
        repeat (12) @(posedge clk_sys);
        #1;
        `CHK({count, running, flag, prot, irq, rreq}, {15'h7FFF, 5'h00}, "reset values")
        @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        #1;
    endtask

    // One-cycle software write: 0 refresh, 1 start, 2 protection bit, 3 flag
    task automatic wrt(int k, logic [7:0] d);
        wdt_wr_s w;
        w = '0;
        case (k)
            0: begin w.refresh_wr = 1'h1; w.refresh_data = d; end
            1: w.start_wr = 1'h1;
            2: begin w.prot_wr = 1'h1; w.prot_data = d[0]; end
            default: begin w.flag_wr = 1'h1; w.flag_data = d[0]; end
        endcase
        @(posedge clk_sys);
        wr <= w;
        @(posedge clk_sys);
        wr <= '0;
        #1;
    endtask

    // Cycles between two counter steps, and the step size
    task automatic period(int exp);
        for (int i = 0; i < 2; i++) begin
            c = count;
            n = 0;
            while (count === c && n < 1000) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
        end
        `CHK(n, exp, "tick spacing")
        `CHK(count, c - 15'h0001, "decrement by one")
    endtask

    // Wait for an underflow pulse, bounded
    task automatic wait_uf(int lim);
        n = 0;
        while (irq !== 1'h1 && rreq !== 1'h1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    // Watchdog against a hang
    initial begin
        // Longest path is the unprotected underflow, about 66k cycles
        #(25 * 90000);
        fails++;
        finish_test();
    end

    // Main sequence
    initial begin
        {psel, csel, rsel, stp, wai, ew1, susp} = '0;
        // Reset from time zero keeps the checks off undefined state
        srst = 1'h1;
        opt = '0;
        wr = '0;
        fails = 0;
        checks = 0;
        seed = 39;
        do_reset(1'h0, 1'h1, 2'h0, 2'h3);
        `CHK({running, count}, {1'h1, 15'h7FFF}, "auto start")
        period(16);
        psel <= 1'h1;
        period(128);
        csel <= 1'h1;
        period(2);
        // Stop, wait and EW1 each freeze the unprotected count; EW1 under flash suspend does not
        for (int k = 0; k < 4; k++) begin
            {stp, wai, ew1, susp} <= (k == 3) ? 4'h3 : (4'h8 >> k);
            repeat (3) @(posedge clk_sys);
            #1;
            c = count;
            repeat (40) @(posedge clk_sys);
            #1;
            `CHK(count === c, k != 3, "halt behaviour")
        end
        {stp, wai, ew1, susp} <= 4'h0;
        // Lone FFh, and FFh after a disarming write, must not reload
        wrt(0, 8'hFF);
        `CHK(count < 15'h7FFF, 1'h1, "lone second byte")
        wrt(0, 8'h00);
        wrt(0, 8'h01 + 8'(xs() % 253));
        wrt(0, 8'hFF);
        `CHK(count < 15'h7FFF, 1'h1, "broken sequence")
        wrt(0, 8'h00);
        repeat (xs() % 5) @(posedge clk_sys);
        wrt(0, 8'hFF);
        `CHK(count, rl(1'h0, 2'h0), "refresh reload")
        // Narrow window refuses an early refresh
        do_reset(1'h0, 1'h1, 2'h0, 2'h0);
        repeat (60) @(posedge clk_sys);
        wrt(0, 8'h00);
        wrt(0, 8'hFF);
        `CHK(count < 15'h7FFF, 1'h1, "refresh outside window")
        // Start on trigger only
        do_reset(1'h1, 1'h1, 2'h0, 2'h3);
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK(running, 1'h0, "waits for trigger")
        // Runtime protection bit set while idle: 0 then 1 sets it, never cleared
        wrt(2, 8'h01);
        `CHK(prot, 1'h0, "set without arming")
        wrt(2, 8'h00);
        wrt(2, 8'h01);
        `CHK(prot, 1'h1, "protection set")
        // Trigger start loads the protected reload, so a refresh is in window
        wrt(1, 8'h00);
        `CHK({running, count}, {1'h1, rl(1'h1, opt.initial_value_sel)}, "triggered start")
        wrt(2, 8'h00);
        `CHK({prot, osc_en}, 2'h3, "sticky and oscillator on")
        wrt(0, 8'h00);
        wrt(0, 8'hFF);
        `CHK(count, rl(1'h1, opt.initial_value_sel), "protected reload")
        // Strap protection with every reload selection
        for (int k = 3; k >= 0; k--) begin
            do_reset(1'h0, 1'h0, 2'(k), 2'h3);
            `CHK({count, prot}, {rl(1'h1, 2'(k)), 1'h0}, "strap reload")
            #25;
            `CHK(osc_en, 1'h1, "oscillator enabled")
        end
        // Protected underflow forces reset even when halted and set for interrupt
        rsel <= 1'h0;
        stp  <= 1'h1;
        wait_uf(3000);
        `CHK({rreq, irq, flag, count}, {3'h5, rl(1'h1, 2'h0)}, "protected underflow")
        #25;
        `CHK(rreq, 1'h0, "reset pulse one cycle")
        wrt(3, 8'h01);
        `CHK(flag, 1'h1, "flag ignores one")
        wrt(3, 8'h00);
        `CHK(flag, 1'h0, "flag cleared")
        stp <= 1'h0;
        // Unprotected underflow raises the interrupt
        do_reset(1'h0, 1'h1, 2'h0, 2'h3);
        wait_uf(70000);
        `CHK({irq, rreq, flag, count}, {3'h5, 15'h7FFF}, "interrupt underflow")
        finish_test();
    end
endmodule // testbench

// >>> wdt_core.sv
// Watchdog timer core: counter, refresh, start, protection and underflow action
//
// Contract
// - 15-bit counter decrements per prescaled tick, or per oscillator pulse when protected
// - CPU clock, or dedicated oscillator when protected
// - Option chooses auto start or start trigger
// - Unprotected counting halts in stop/wait, and in EW1 unless flash suspended
// - Reload on 00h-FFh refresh, reset, underflow
// - Reload 7FFFh, or selected value when protected
// - Underflow gives interrupt or reset; protected forces reset
// - Prescaler divides by 16 or 128
// - Sub clock forces divide by 2
// - Protection from option or runtime bit
// - Window field selects refresh acceptance portion
// - Underflow sets flag; write 0 clears
// - Protection bit set by 0-then-1, sticky
// - Protection starts oscillator, forces reset action
// - Refresh accepted only inside window
`timescale 1ns/10ps
module wdt_core
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Options and software writes
    input  wire wdt_opt_s    opt,
    input  wire wdt_wr_s     wr,
    // Configuration levels
    input  wire logic        prescaler_select_bit,    // Control register select
    input  wire logic        system_clock_select_bit, // Clock mode register 0 select
    input  wire logic        underflow_reset_sel,     // 1: reset, 0: interrupt
    // Count source and halt conditions
    input  wire logic        dedicated_osc_clock,     // One-cycle pulse per oscillator period
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    input  wire logic        erase_write_mode_one,    // Flash command running in EW1
    input  wire logic        flash_suspend,
    // Status outputs
    output logic [14:0]      count,
    output logic             running,
    output logic             watchdog_detect_flag,
    output logic             protection_mode_bit,
    output logic             osc_enable,
    output logic             wdt_irq,                 // One-cycle pulse
    output logic             wdt_reset_req            // One-cycle pulse
);
    // Counter and run state
    logic [14:0] cnt_reg, cnt_next;
    wdt_state_e  st_reg, st_next;
    // Refresh sequence and protection arming
    logic        ref_arm_reg, ref_arm_next;   // Last refresh write was 00h
    logic        prot_arm_reg, prot_arm_next; // Last protection write was 0
    logic        prot_bit_reg, prot_bit_next; // Runtime protection bit
    // Status and event outputs
    logic        flag_reg, flag_next;
    logic        irq_reg, irq_next;
    logic        rst_reg, rst_next;
    logic        osc_reg, osc_next;
    // Options caught during reset
    wdt_opt_s    opt_reg;
    // Derived terms
    logic        prot;        // Protection in force
    logic        halted;      // Counting stopped by a low-power or flash state
    logic        pre_tick;    // Prescaled CPU tick
    logic        dec;         // Counter steps this cycle
    logic        underflow;
    logic        refresh_ok;
    logic        in_window;
    logic [14:0] reload;
    logic [14:0] win_thr;

    // Protection from strap (active low) or runtime bit
    assign prot = ~opt_reg.after_reset_protection_option | prot_bit_reg;

    // Prescaler runs on every CPU clock while unprotected, counting and not halted
    wdt_prescaler u_pre (
        .clk_sys                 (clk_sys),
        .srst                    (srst),
        .src_tick                (~prot & (st_reg == ST_COUNT) & ~halted),
        .prescaler_select_bit    (prescaler_select_bit),
        .system_clock_select_bit (system_clock_select_bit),
        .pre_tick                (pre_tick)
    );

    // Reload value and refresh window threshold
    always_comb begin
        reload = RELOAD_NORMAL;
        if (prot) begin
            case (opt_reg.initial_value_sel)
                2'h0:    reload = RELOAD_SEL0;
                2'h1:    reload = RELOAD_SEL1;
                2'h2:    reload = RELOAD_SEL2;
                default: reload = RELOAD_SEL3;
            endcase
        end
        // Window is the last part of the period before underflow
        case (opt_reg.refresh_window_sel)
            WIN_25:  win_thr = reload >> 2;
            WIN_50:  win_thr = reload >> 1;
            WIN_75:  win_thr = reload - (reload >> 2);
            default: win_thr = reload;
        endcase
        in_window = (cnt_reg <= win_thr);
    end

    // Halt only unprotected; protected count never stops
    assign halted = ~prot & (stop_mode | wait_mode | (erase_write_mode_one & ~flash_suspend));
    // Count source: prescaled CPU clock or oscillator pulse
    assign dec = (st_reg == ST_COUNT) & (prot ? dedicated_osc_clock : (pre_tick & ~halted));
    assign underflow = dec & (cnt_reg == CNT_ZERO);
    // FFh accepted only directly after 00h and inside the window
    assign refresh_ok = wr.refresh_wr & (wr.refresh_data == REFRESH_SECOND) & ref_arm_reg & in_window;

    // Counter, run state and refresh sequence next values
    always_comb begin
        cnt_next     = cnt_reg;
        st_next      = st_reg;
        ref_arm_next = ref_arm_reg;
        case (st_reg)
            ST_IDLE: begin
                // Start automatically or on trigger write
                if (~opt_reg.start_select_option | wr.start_wr) begin
                    st_next  = ST_COUNT;
                    cnt_next = reload;
                end
            end
            ST_COUNT: begin
                if (underflow | refresh_ok) begin
                    cnt_next = reload;
                end else if (dec) begin
                    cnt_next = cnt_reg - 15'h0001;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        // Any other refresh write breaks the sequence
        if (wr.refresh_wr) begin
            ref_arm_next = (wr.refresh_data == REFRESH_FIRST);
        end
    end

    // Protection bit, flag and underflow action next values
    always_comb begin
        prot_arm_next = prot_arm_reg;
        prot_bit_next = prot_bit_reg;
        flag_next     = flag_reg;
        if (wr.prot_wr) begin
            // Write 1 counts only right after a write of 0; never cleared
            if (wr.prot_data & prot_arm_reg) begin
                prot_bit_next = 1'b1;
            end
            prot_arm_next = ~wr.prot_data;
        end
        // Write 0 clears, write 1 ignored; underflow wins over the clear
        if (wr.flag_wr & ~wr.flag_data) begin
            flag_next = 1'b0;
        end
        if (underflow) begin
            flag_next = 1'b1;
        end
        // Protection forces reset action
        rst_next = underflow & (prot | underflow_reset_sel);
        irq_next = underflow & ~prot & ~underflow_reset_sel;
        osc_next = prot;
    end

    // Registers; options sampled while reset is held
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            opt_reg      <= opt;
            cnt_reg      <= RELOAD_NORMAL;
            st_reg       <= ST_IDLE;
            ref_arm_reg  <= 1'b0;
            prot_arm_reg <= 1'b0;
            prot_bit_reg <= 1'b0;
            flag_reg     <= 1'b0;
            irq_reg      <= 1'b0;
            rst_reg      <= 1'b0;
            osc_reg      <= 1'b0;
        end else begin
            cnt_reg      <= cnt_next;
            st_reg       <= st_next;
            ref_arm_reg  <= ref_arm_next;
            prot_arm_reg <= prot_arm_next;
            prot_bit_reg <= prot_bit_next;
            flag_reg     <= flag_next;
            irq_reg      <= irq_next;
            rst_reg      <= rst_next;
            osc_reg      <= osc_next;
        end
    end

    // Outputs straight from flops
    assign count                = cnt_reg;
    assign running              = (st_reg == ST_COUNT);
    assign watchdog_detect_flag = flag_reg;
    assign protection_mode_bit  = prot_bit_reg;
    assign osc_enable           = osc_reg;
    assign wdt_irq              = irq_reg;
    assign wdt_reset_req        = rst_reg;

    // Checks
    sequence s_underflow;
        dec && cnt_reg == CNT_ZERO;
    endsequence

    a_dec_by_one: assert property (@(posedge clk_sys) disable iff (srst)
        dec && cnt_reg != CNT_ZERO && !refresh_ok |=> cnt_reg == $past(cnt_reg) - 15'h0001)
        else $error("counter did not step by one");
    a_underflow_reload: assert property (@(posedge clk_sys) disable iff (srst)
        s_underflow |=> cnt_reg == $past(reload) && watchdog_detect_flag)
        else $error("underflow did not reload and flag");
    a_refresh_reload: assert property (@(posedge clk_sys) disable iff (srst)
        refresh_ok |-> ref_arm_reg ##1 cnt_reg == $past(reload))
        else $error("refresh without proper sequence");
    a_reload_normal: assert property (@(posedge clk_sys) disable iff (srst)
        !prot |-> reload == RELOAD_NORMAL)
        else $error("unprotected reload not 7FFFh");
    a_halt_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !prot && (stop_mode || wait_mode) && !wr.refresh_wr |=> cnt_reg == $past(cnt_reg))
        else $error("counter moved while halted");
    a_prot_sticky: assert property (@(posedge clk_sys) disable iff (srst)
        protection_mode_bit |=> protection_mode_bit)
        else $error("protection bit cleared");
    a_prot_action: assert property (@(posedge clk_sys) disable iff (srst)
        s_underflow ##0 prot |=> wdt_reset_req && !wdt_irq ##1 osc_enable)
        else $error("protected underflow did not force reset");
    a_irq_action: assert property (@(posedge clk_sys) disable iff (srst)
        s_underflow ##0 !prot && !underflow_reset_sel |=> wdt_irq && !wdt_reset_req)
        else $error("interrupt action missing");
    a_auto_start: assert property (@(posedge clk_sys)
        $fell(srst) && !opt_reg.start_select_option |=> running)
        else $error("auto start did not run");
    // Refresh write outside the window leaves the count to its normal step
    a_window_only: assert property (@(posedge clk_sys) disable iff (srst)
        running && wr.refresh_wr && !in_window |=>
            cnt_reg == ($past(dec) ? $past(cnt_reg) - 15'h0001 : $past(cnt_reg)))
        else $error("refresh accepted outside window");
endmodule // wdt_core

// >>> wdt_pkg.sv
// Shared constants and carrier types for the watchdog timer core
package wdt_pkg;
    // Counter geometry and reload values
    localparam int          CNT_W         = 15;
    localparam logic [14:0] RELOAD_NORMAL = 15'h7FFF;
    localparam logic [14:0] RELOAD_SEL0   = 15'h03FF;
    localparam logic [14:0] RELOAD_SEL1   = 15'h0FFF;
    localparam logic [14:0] RELOAD_SEL2   = 15'h1FFF;
    localparam logic [14:0] RELOAD_SEL3   = 15'h3FFF;
    localparam logic [14:0] CNT_ZERO      = 15'h0000;
    // Prescaler width, terminal counts (divide ratio minus one) and reset value
    localparam int          PRE_W         = 7;
    localparam logic [6:0]  PRE_TC_16     = 7'h0F;
    localparam logic [6:0]  PRE_TC_128    = 7'h7F;
    localparam logic [6:0]  PRE_TC_2      = 7'h01;
    localparam logic [6:0]  PRE_RST       = 7'h00;
    // Refresh register data codes
    localparam logic [7:0]  REFRESH_FIRST  = 8'h00;
    localparam logic [7:0]  REFRESH_SECOND = 8'hFF;
    // Refresh window selection codes
    localparam logic [1:0]  WIN_25  = 2'h0;
    localparam logic [1:0]  WIN_50  = 2'h1;
    localparam logic [1:0]  WIN_75  = 2'h2;
    localparam logic [1:0]  WIN_100 = 2'h3;

    // Run state of the counter
    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_COUNT = 1'b1
    } wdt_state_e;

    // Nonvolatile option bits, sampled while reset is held
    typedef struct packed {
        logic       start_select_option;           // 0: auto start, 1: wait for start trigger
        logic       after_reset_protection_option; // 0: protection on after reset
        logic [1:0] initial_value_sel;             // {hi, lo} reload in protection mode
        logic [1:0] refresh_window_sel;            // {hi, lo} refresh window
    } wdt_opt_s;

    // Software write strobes with their data
    typedef struct packed {
        logic       refresh_wr;       // Write to refresh_register
        logic [7:0] refresh_data;
        logic       start_wr;         // Write to start_trigger_register
        logic       prot_wr;          // Write to protection_mode_register
        logic       prot_data;        // Value written to protection_mode_bit
        logic       flag_wr;          // Write to watchdog_detect_flag
        logic       flag_data;
    } wdt_wr_s;
endpackage

// >>> wdt_prescaler.sv
// Prescaler dividing the CPU-clock count source by 16, 128 or 2
`timescale 1ns/10ps
module wdt_prescaler
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Control
    input  wire logic       src_tick,                // Count source pulse
    input  wire logic       prescaler_select_bit,    // 0: /16, 1: /128
    input  wire logic       system_clock_select_bit, // 1: sub clock, forces /2
    // Output
    output logic            pre_tick                 // One pulse per divided period
);
    logic [6:0] div_reg;     // Divider count
    logic [6:0] div_next;
    logic       tick_reg;    // Registered output pulse
    logic       tick_next;
    logic [6:0] tc;          // Terminal count in force

    // Divider next state
    always_comb begin
        // Sub clock overrides the select bit
        if (system_clock_select_bit) begin
            tc = PRE_TC_2;
        end else begin
            tc = prescaler_select_bit ? PRE_TC_128 : PRE_TC_16;
        end
        div_next  = div_reg;
        tick_next = 1'b0;
        if (src_tick) begin
            // Wrap at or past terminal; guards a ratio change mid-count
            if (div_reg >= tc) begin
                div_next  = PRE_RST;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 7'h01;
            end
        end
    end

    // Divider registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_reg  <= PRE_RST;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign pre_tick = tick_reg;

    // Divide by 2 in sub-clock mode: two source pulses per tick
    a_sub_div_two: assert property (@(posedge clk_sys) disable iff (srst)
        system_clock_select_bit && src_tick && div_reg == PRE_RST |=> !pre_tick)
        else $error("sub clock divider ticked too early");
    // A tick is always caused by a source pulse
    a_tick_cause: assert property (@(posedge clk_sys) disable iff (srst)
        pre_tick |-> $past(src_tick))
        else $error("prescaler tick without source pulse");
endmodule // wdt_prescaler
